// *** gpx_port.sv ***
// Eight-pin GPIO port with alternate functions, interrupt and AXI4-Lite.
`timescale 1ns/1ps
`include "gpx_defs.svh"

// What this block does
// - Interrupt input pin event raises CPU request
// - Each pin detects independently per sensitivity
// - Qualify each pin, then OR together
// - Hidden request latch clears on vector fetch
// - Rewriting sensitivity bits discards pending request
// - Output mode drives pin from data latch
// - Option bit picks push-pull or open-drain
// - Alternate output function overrides standard pin settings
// - Peripheral output forces output, peripheral drive type
// - Peripheral input: software sets input, reads pin
// - Input with alternate output reads alternate value
// - Output with alternate input feeds data latch
// - Low-power modes keep state; interrupt wakes
// - Interrupt needs interrupt mode and cleared mask
// - Standard pins: four direction/option mode encodings
// - Pull-up interrupt pins: option 1 pull-up interrupt
// - Floating interrupt pins: option 1 floating interrupt
// - Input mode reads pin; writes touch latch only
// - All registers reset to zero
module gpx_port #(
    parameter int            NPINS = 8,
    parameter logic [15:0]   KIND  = 16'h0000
) (
    // Clock and reset.
    input  wire logic                  CORE_CLK,
    input  wire logic                  NRST,
    // Register bus.
    input  wire gpx_pkg::gpx_axi_req_t AXI_REQ,
    output      gpx_pkg::gpx_axi_rsp_t AXI_RSP,
    // Pads.
    input  wire logic [7:0]            PIN_IN,
    output      gpx_pkg::gpx_pad_t     PAD,
    // Alternate functions.
    input  wire gpx_pkg::gpx_alt_t     ALT,
    output      logic [7:0]            ALT_IN,
    // CPU interrupt interface.
    input  wire logic                  VECTOR_FETCH,
    input  wire logic                  IRQ_MASKED,
    input  wire logic                  LOW_POWER,
    output      logic                  IRQ_REQ,
    output      logic                  WAKEUP
);
    import gpx_pkg::*;

    // The per-pin logic and the byte-wide registers serve eight pins only.
    if (NPINS != 8) begin : g_bad_npins
        $error("gpx_port serves exactly eight pins");
    end
    // Kind code 3 has no pin behaviour behind it.
    for (genvar k = 0; k < 8; k++) begin : g_kind_chk
        if (KIND[2*k +: 2] == 2'h3) begin : g_bad_kind
            $error("gpx_port pin kind code 3 is not served");
        end
    end

    typedef struct packed {
        logic [7:0]  data;
        logic [7:0]  dir;
        logic [7:0]  opt;
        gpx_sens_t   sens;
        logic [7:0]  sync1;
        logic [7:0]  sync2;
        logic [7:0]  prev;
        logic        pend;
        gpx_bstate_t wst;
        logic [1:0]  bresp;
        gpx_bstate_t rst;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        aw_got;
        logic        w_got;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
    } gpx_state_t;

    gpx_state_t st_q;
    gpx_state_t st_d;

    // ------------------------------------------------------------
    // Pin kind decoding
    // ------------------------------------------------------------
    function automatic gpx_kind_t kind_of(input int unsigned idx);
        kind_of = gpx_kind_t'(KIND[2*idx +: 2]);
    endfunction

    logic [7:0] irq_pin;
    logic [7:0] pu_cap;
    logic [7:0] pin_ev;
    logic [7:0] rd_view;
    logic       any_ev;

    // ------------------------------------------------------------
    // Per-pin pad, read-back and event logic
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            assign irq_pin[g] = (kind_of(g) != GPX_PIN_STD);
            assign pu_cap[g]  = (kind_of(g) != GPX_PIN_IRQ_FL);
            always_comb begin
                // Alternate output wins over the standard settings.
                if (ALT.alt_en[g] && ALT.alt_out_en[g]) begin
                    PAD.oe[g]  = ALT.alt_od[g] ? ~ALT.alt_out[g] : 1'b1;
                    PAD.out[g] = ALT.alt_out[g];
                end else if (st_q.dir[g]) begin
                    // Open-drain leaves a 1 floating.
                    PAD.oe[g]  = st_q.opt[g] ? 1'b1 : ~st_q.data[g];
                    PAD.out[g] = st_q.data[g];
                end else begin
                    PAD.oe[g]  = 1'b0;
                    PAD.out[g] = 1'b0;
                end
                // Pull-up only in pull-up input mode.
                PAD.pull_up[g] = ~st_q.dir[g] & st_q.opt[g] & pu_cap[g]
                                 & ~(ALT.alt_en[g] & ALT.alt_out_en[g]);
                // Read-back.
                if (!st_q.dir[g] && ALT.alt_en[g] && ALT.alt_out_en[g]) begin
                    rd_view[g] = ALT.alt_out[g];
                end else if (st_q.dir[g]) begin
                    rd_view[g] = st_q.data[g];
                end else begin
                    rd_view[g] = st_q.sync2[g];
                end
                // Peripheral input sees latch when pin is output.
                ALT_IN[g] = st_q.dir[g] ? st_q.data[g] : st_q.sync2[g];
                // Qualify each interrupt input by sensitivity.
                pin_ev[g] = 1'b0;
                if (irq_pin[g] && !st_q.dir[g] && st_q.opt[g]) begin
                    case (st_q.sens)
                        GPX_SENS_FALL_LOW: pin_ev[g] = ~st_q.sync2[g];
                        GPX_SENS_RISE:
                            pin_ev[g] = st_q.sync2[g] & ~st_q.prev[g];
                        GPX_SENS_FALL:
                            pin_ev[g] = ~st_q.sync2[g] & st_q.prev[g];
                        GPX_SENS_BOTH:
                            pin_ev[g] = st_q.sync2[g] ^ st_q.prev[g];
                        default:        pin_ev[g] = 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    assign any_ev = |pin_ev;

    // ------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `GPX_OFF_DATA) || (a == `GPX_OFF_DIR)
              || (a == `GPX_OFF_OPT)  || (a == `GPX_OFF_SENS)
              || (a == `GPX_OFF_PIN)  || (a == `GPX_OFF_IRQCFG)
              || (a == `GPX_OFF_STAT);
    endfunction

    logic wr_go;
    logic [31:0] rd_word;

    assign wr_go = (st_q.wst == GPX_BUS_IDLE) && st_q.aw_got && st_q.w_got;

    always_comb begin
        case (AXI_REQ.araddr)
            `GPX_OFF_DATA:   rd_word = {24'h000000, rd_view};
            `GPX_OFF_DIR:    rd_word = {24'h000000, st_q.dir};
            `GPX_OFF_OPT:    rd_word = {24'h000000, st_q.opt};
            `GPX_OFF_SENS:   rd_word = {30'h00000000, st_q.sens};
            `GPX_OFF_PIN:    rd_word = {24'h000000, st_q.sync2};
            `GPX_OFF_IRQCFG: rd_word = {16'h0000, KIND};
            `GPX_OFF_STAT:   rd_word = {29'h00000000, WAKEUP,
                                        IRQ_MASKED, 1'b0};
            default:         rd_word = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // Two-stage synchroniser ahead of detection.
        st_d.sync1 = PIN_IN;
        st_d.sync2 = st_q.sync1;
        st_d.prev  = st_q.sync2;
        // Address and data accepted in either order.
        if (AXI_REQ.awvalid && !st_q.aw_got && st_q.wst == GPX_BUS_IDLE) begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = AXI_REQ.awaddr;
        end
        if (AXI_REQ.wvalid && !st_q.w_got && st_q.wst == GPX_BUS_IDLE) begin
            st_d.w_got = 1'b1;
            st_d.wdata = AXI_REQ.wdata;
            st_d.wstrb = AXI_REQ.wstrb;
        end
        if (st_q.pend && VECTOR_FETCH) begin
            st_d.pend = 1'b0;
        end
        if (wr_go) begin
            st_d.wst    = GPX_BUS_RESP;
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bresp  = mapped(st_q.awaddr) ? `GPX_RESP_OKAY
                                              : `GPX_RESP_SLVERR;
            if (st_q.wstrb[0]) begin
                case (st_q.awaddr)
                    `GPX_OFF_DATA: st_d.data = st_q.wdata[7:0];
                    `GPX_OFF_DIR:  st_d.dir  = st_q.wdata[7:0];
                    `GPX_OFF_OPT:  st_d.opt  = st_q.wdata[7:0];
                    `GPX_OFF_SENS: begin
                        st_d.sens = gpx_sens_t'(st_q.wdata[1:0]);
                        st_d.pend = 1'b0;
                    end
                    default: st_d.data = st_q.data;
                endcase
            end
        end
        // A new event wins over any clear in the same cycle.
        if (any_ev) begin
            st_d.pend = 1'b1;
        end
        if (st_q.wst == GPX_BUS_RESP && AXI_REQ.bready) begin
            st_d.wst = GPX_BUS_IDLE;
        end
        if (st_q.rst == GPX_BUS_IDLE && AXI_REQ.arvalid) begin
            st_d.rst   = GPX_BUS_RESP;
            st_d.rdata = rd_word;
            st_d.rresp = mapped(AXI_REQ.araddr) ? `GPX_RESP_OKAY
                                                : `GPX_RESP_SLVERR;
        end else if (st_q.rst == GPX_BUS_RESP && AXI_REQ.rready) begin
            st_d.rst = GPX_BUS_IDLE;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign IRQ_REQ = st_q.pend & ~IRQ_MASKED;
    // Pins keep their state in low power; a request wakes the core.
    assign WAKEUP  = st_q.pend & LOW_POWER;

    assign AXI_RSP.awready = (st_q.wst == GPX_BUS_IDLE) && !st_q.aw_got;
    assign AXI_RSP.wready  = (st_q.wst == GPX_BUS_IDLE) && !st_q.w_got;
    assign AXI_RSP.bvalid  = (st_q.wst == GPX_BUS_RESP);
    assign AXI_RSP.bresp   = st_q.bresp;
    assign AXI_RSP.arready = (st_q.rst == GPX_BUS_IDLE);
    assign AXI_RSP.rvalid  = (st_q.rst == GPX_BUS_RESP);
    assign AXI_RSP.rdata   = st_q.rdata;
    assign AXI_RSP.rresp   = st_q.rresp;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_event_sets_pend: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        any_ev |=> st_q.pend)
        else $error("event did not set pending request");

    a_fetch_clears: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        st_q.pend && VECTOR_FETCH && !any_ev && !wr_go |=> !st_q.pend)
        else $error("vector fetch did not clear request");

    a_sens_write_clear: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        wr_go && st_q.awaddr == `GPX_OFF_SENS && st_q.wstrb[0] && !any_ev
        |=> !st_q.pend)
        else $error("sensitivity rewrite did not discard request");

    a_mask_gates_irq: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        IRQ_MASKED |-> !IRQ_REQ)
        else $error("masked request reached the CPU");

    a_opendrain_float: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        st_q.dir[0] && !st_q.opt[0] && st_q.data[0] && !ALT.alt_en[0]
        |-> !PAD.oe[0])
        else $error("open-drain pin drove a one");

    a_input_no_drive: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        !st_q.dir[1] && !ALT.alt_en[1] |-> !PAD.oe[1])
        else $error("input pin was driven");

    a_sync_delay: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        ##2 st_q.sync2 == $past(PIN_IN, 2))
        else $error("pin synchroniser delay wrong");

    a_write_resp: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        wr_go |=> AXI_RSP.bvalid)
        else $error("write response missing");

    a_read_resp: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        AXI_REQ.arvalid && AXI_RSP.arready |=> AXI_RSP.rvalid)
        else $error("read response missing");

    a_alt_overrides: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        ALT.alt_en[0] && ALT.alt_out_en[0] && !ALT.alt_od[0]
        |-> PAD.oe[0] && PAD.out[0] == ALT.alt_out[0])
        else $error("alternate output did not own the pin");

    a_pushpull_drive: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        st_q.dir[2] && st_q.opt[2] && !ALT.alt_en[2]
        |-> PAD.oe[2] && PAD.out[2] == st_q.data[2])
        else $error("push-pull pin not driven from latch");

    a_alt_in_latch: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        st_q.dir[1] |-> ALT_IN[1] == st_q.data[1])
        else $error("peripheral input did not see the latch");

    a_pullup_mode: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        PAD.pull_up[3] |-> !st_q.dir[3] && st_q.opt[3])
        else $error("pull-up on outside pull-up input mode");

    a_irq_unmasked: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        st_q.pend && !IRQ_MASKED |-> IRQ_REQ)
        else $error("unmasked pending request not raised");

    a_wake_request: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        st_q.pend && LOW_POWER |-> WAKEUP)
        else $error("pending request did not wake the core");
endmodule

// *** gpx_defs.svh ***
// Offsets, field positions, reset values and widths of the GPIO port.
`ifndef GPX_DEFS_SVH
`define GPX_DEFS_SVH
`define GPX_OFF_DATA   12'h000
`define GPX_OFF_DIR    12'h004
`define GPX_OFF_OPT    12'h008
`define GPX_OFF_SENS   12'h00C
`define GPX_OFF_PIN    12'h010
`define GPX_OFF_IRQCFG 12'h014
`define GPX_OFF_STAT   12'h018
`define GPX_RST_BYTE   8'h00
`define GPX_RST_SENS   2'h0
`define GPX_SENS_W     2
`define GPX_STAT_PEND  0
`define GPX_STAT_MASK  1
`define GPX_STAT_WAKE  2
`define GPX_RESP_OKAY  2'h0
`define GPX_RESP_SLVERR 2'h2
`endif

// *** gpx_pkg.sv ***
// Types shared by the GPIO port: bus channels, pin groups, modes and state.
package gpx_pkg;
    typedef enum logic [1:0] {
        GPX_SENS_FALL_LOW = 2'h0,
        GPX_SENS_RISE     = 2'h1,
        GPX_SENS_FALL     = 2'h2,
        GPX_SENS_BOTH     = 2'h3
    } gpx_sens_t;
    typedef enum logic [1:0] {
        GPX_PIN_STD    = 2'h0,
        GPX_PIN_IRQ_PU = 2'h1,
        GPX_PIN_IRQ_FL = 2'h2
    } gpx_kind_t;
    typedef enum logic [1:0] {
        GPX_BUS_IDLE = 2'h0,
        GPX_BUS_RESP = 2'h1
    } gpx_bstate_t;
    typedef struct packed {
        logic [11:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [11:0] araddr;
        logic        arvalid;
        logic        rready;
    } gpx_axi_req_t;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } gpx_axi_rsp_t;
    typedef struct packed {
        logic [7:0] alt_en;
        logic [7:0] alt_out_en;
        logic [7:0] alt_out;
        logic [7:0] alt_od;
    } gpx_alt_t;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull_up;
    } gpx_pad_t;
endpackage

// *** gpx_board.sv ***
// Board-side model of the eight pads: external drivers, pull-ups, floating levels.
`timescale 1ns/1ps
module gpx_board (
    // Clock.
    input  wire logic              clk,
    // Pad side of the port.
    input  wire gpx_pkg::gpx_pad_t pad,
    // Board drivers.
    input  wire logic [7:0]        ext_drv,
    input  wire logic [7:0]        ext_en,
    // Resolved pin level.
    output      logic [7:0]        pin
);
    import gpx_pkg::*;
    logic [7:0] float_q = 8'h55;
    // A released pin with no pull-up has no defined level, so it wanders.
    always @(posedge clk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad.oe[i])
                pin[i] = pad.out[i];
            else if (ext_en[i])
                pin[i] = ext_drv[i];
            else if (pad.pull_up[i])
                pin[i] = 1'b1;
            else
                pin[i] = float_q[i];
        end
    end
endmodule

// *** gpx_port_tb_top.sv ***
// Self-checking testbench for the GPIO port.
`timescale 1ns/1ps
`include "gpx_defs.svh"
module gpx_port_tb_top;
    import gpx_pkg::*;
    localparam logic [15:0] KIND = 16'hA500;
    logic         core_clk = 1'b0;
    logic         nrst     = 1'b0;
    gpx_axi_req_t req      = '0;
    gpx_axi_rsp_t rsp;
    gpx_pad_t     pad;
    gpx_alt_t     alt      = '0;
    logic [7:0]   pin;
    logic [7:0]   alt_in;
    logic [7:0]   ext_drv  = 8'h00;
    logic [7:0]   ext_en   = 8'hFF;
    logic         fetch    = 1'b0;
    logic         masked   = 1'b0;
    logic         lowp     = 1'b0;
    logic         irq;
    logic         wake;
    logic [31:0]  rdat;
    logic [1:0]   rrsp;
    logic [1:0]   brsp;
    int           errors   = 0;
    int           cmp_count = 0;

    always #12.5 core_clk = ~core_clk;

    gpx_port #(.NPINS(8), .KIND(KIND)) dut (
        .CORE_CLK(core_clk), .NRST(nrst), .AXI_REQ(req), .AXI_RSP(rsp),
        .PIN_IN(pin), .PAD(pad), .ALT(alt), .ALT_IN(alt_in),
        .VECTOR_FETCH(fetch), .IRQ_MASKED(masked), .LOW_POWER(lowp),
        .IRQ_REQ(irq), .WAKEUP(wake)
    );
    gpx_board board (
        .clk(core_clk), .pad(pad), .ext_drv(ext_drv), .ext_en(ext_en),
        .pin(pin)
    );

    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo();
        errors++;
        $display("BAD t=%0t bus answer never came", $time);
        end_sim();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic pulse();
        @(posedge core_clk);
        fetch <= 1'b1;
        @(posedge core_clk);
        fetch <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int   n;
        logic b;
        n = 0;
        b = 1'b0;
        @(posedge core_clk);
        req.awaddr  <= a;
        req.wdata   <= {24'h0, d};
        req.wstrb   <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        while (!b && n < 40) begin
            @(posedge core_clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            b    = rsp.bvalid;
            brsp = rsp.bresp;
            n++;
        end
        req.bready <= 1'b0;
        if (!b) tmo();
    endtask
    task automatic rd(input logic [11:0] a);
        int   n;
        logic r;
        n = 0;
        r = 1'b0;
        @(posedge core_clk);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        while (!r && n < 40) begin
            @(posedge core_clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            r    = rsp.rvalid;
            rdat = rsp.rdata;
            rrsp = rsp.rresp;
            n++;
        end
        req.rready <= 1'b0;
        if (!r) tmo();
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(16);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(12'(4 * i));
            chk(rdat, 32'h0);
        end
        rd(12'h01C);
        chk(32'(rrsp), 32'(`GPX_RESP_SLVERR));
        wr(12'h01C, 8'hFF);
        chk(32'(brsp), 32'(`GPX_RESP_SLVERR));
        rd(`GPX_OFF_IRQCFG);
        chk(rdat, 32'(KIND));
        wr(`GPX_OFF_DATA, 8'hA5);
        chk(32'(brsp), 32'(`GPX_RESP_OKAY));
        wr(`GPX_OFF_DIR, 8'h0F);
        wr(`GPX_OFF_OPT, 8'h0F);
        chk(32'(pad.oe), 32'h0F);
        chk(32'(pad.out & 8'h0F), 32'h05);
        rd(`GPX_OFF_DATA);
        chk(rdat, 32'h05);
        chk(32'(rrsp), 32'(`GPX_RESP_OKAY));
        wr(`GPX_OFF_OPT, 8'h00);
        chk(32'(pad.oe), 32'h0A);
        ext_en <= 8'hF0;
        wr(`GPX_OFF_DIR, 8'h00);
        wr(`GPX_OFF_OPT, 8'hFF);
        chk(32'(pad.pull_up), 32'h3F);
        chk(32'(pad.oe), 32'h00);
        cyc(4);
        rd(`GPX_OFF_DATA);
        chk(rdat, 32'h0F);
        rd(`GPX_OFF_PIN);
        chk(rdat, 32'h0F);
        // Alternate functions on standard pins 0-2: peripheral output, latch and pin inputs.
        ext_en  <= 8'hFF;
        ext_drv <= 8'h04;
        wr(`GPX_OFF_OPT, 8'h00);
        wr(`GPX_OFF_DATA, 8'h02);
        wr(`GPX_OFF_DIR, 8'h02);
        alt <= '{8'h07, 8'h01, 8'h01, 8'h00};
        cyc(4);
        chk(32'({pad.oe[0], pad.out[0]}), 32'h3);
        chk(32'(alt_in & 8'h06), 32'h06);
        rd(`GPX_OFF_DATA);
        chk(rdat & 32'h07, 32'h07);
        alt.alt_od <= 8'h01;
        cyc(1);
        chk(32'(pad.oe[0]), 32'h0);
        alt     <= '0;
        ext_drv <= 8'h00;
        wr(`GPX_OFF_DIR, 8'h00);
        wr(`GPX_OFF_OPT, 8'h40);
        for (int s = 0; s < 4; s++) begin
            wr(`GPX_OFF_SENS, 8'(s));
            pulse();
            ext_drv <= 8'h40;
            cyc(4);
            chk(32'(irq), 32'(s != 2));
            pulse();
            cyc(4);
            ext_drv <= 8'h00;
            cyc(4);
            chk(32'(irq), 32'(s != 1));
            pulse();
        end
        wr(`GPX_OFF_SENS, 8'h01);
        wr(`GPX_OFF_OPT, 8'h00);
        pulse();
        ext_drv <= 8'h40;
        cyc(4);
        chk(32'(irq), 32'h0);
        wr(`GPX_OFF_OPT, 8'h50);
        masked  <= 1'b1;
        lowp    <= 1'b1;
        ext_drv <= 8'h50;
        cyc(4);
        chk(32'({irq, wake}), 32'h1);
        rd(`GPX_OFF_STAT);
        chk(rdat, 32'h6);
        masked <= 1'b0;
        cyc(1);
        chk(32'(irq), 32'h1);
        wr(`GPX_OFF_SENS, 8'h01);
        chk(32'({irq, wake}), 32'h0);
        end_sim();
    end
endmodule
